// ### rtl/blau_map.vh
/*
 Opcode, state, step and zero constants for the byte logic/arithmetic unit.
 Assumes inclusion by the unit's design files only.
*/
`ifndef BLAU_MAP_VH
`define BLAU_MAP_VH
`define BLAU_OP_OR 8'hF1
`define BLAU_OP_ORI 8'hF9
`define BLAU_OP_XOR 8'hF3
`define BLAU_OP_XRI 8'hFB
`define BLAU_OP_AND 8'hF2
`define BLAU_OP_ANDI 8'hFA
`define BLAU_OP_SHR 8'hF6
`define BLAU_OP_RSHR 8'h76
`define BLAU_OP_SHIFT_LEFT 8'hFE
`define BLAU_OP_RSHL 8'h7E
`define BLAU_OP_ADD 8'hF4
`define BLAU_OP_ADDI 8'hFC
`define BLAU_OP_ADC 8'h74
`define BLAU_OP_ADCI 8'h7C
`define BLAU_OP_RSUB 8'hF5
`define BLAU_OP_RSUBI 8'hFD
`define BLAU_OP_RSUBB 8'h75
`define BLAU_PC_STEP 16'h0001
`define BLAU_BYTE_ZERO 8'h00
`define BLAU_ADDR_ZERO 16'h0000
`define BLAU_ST_FETCH 3'b001
`define BLAU_ST_READ 3'b010
`define BLAU_ST_EXEC 3'b100
`endif

// ### rtl/blau_alu.v
/*
 Combinational 8-bit ALU for the logic, shift and add/reverse-subtract group.
 Assumes opcode and operands are stable while the result is consumed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blau_map.vh"
module blau_alu (
    input wire [7:0] opcode,
    input wire [7:0] acc,
    input wire [7:0] mem_byte,
    input wire carry_in,
    output reg [7:0] result,
    output reg carry_out,
    output reg carry_we,
    output reg known
);
    reg [8:0] sum;
    always @*
    begin
        sum = 9'h000;
        result = acc;
        carry_out = carry_in;
        carry_we = 1'b0;
        known = 1'b1;
        case (opcode)
            `BLAU_OP_OR, `BLAU_OP_ORI:
                result = acc | mem_byte;
            `BLAU_OP_XOR, `BLAU_OP_XRI:
                result = acc ^ mem_byte;
            `BLAU_OP_AND, `BLAU_OP_ANDI:
                result = acc & mem_byte;
            `BLAU_OP_SHR:
            begin
                result = {1'b0, acc[7:1]};
                carry_out = acc[0];
                carry_we = 1'b1;
            end
            `BLAU_OP_RSHR:
            begin
                result = {carry_in, acc[7:1]};
                carry_out = acc[0];
                carry_we = 1'b1;
            end
            `BLAU_OP_SHIFT_LEFT:
            begin
                result = {acc[6:0], 1'b0};
                carry_out = acc[7];
                carry_we = 1'b1;
            end
            `BLAU_OP_RSHL:
            begin
                result = {acc[6:0], carry_in};
                carry_out = acc[7];
                carry_we = 1'b1;
            end
            `BLAU_OP_ADD, `BLAU_OP_ADDI:
            begin
                // Old carry ignored for plain add
                sum = {1'b0, mem_byte} + {1'b0, acc};
                result = sum[7:0];
                carry_out = sum[8];
                carry_we = 1'b1;
            end
            `BLAU_OP_ADC, `BLAU_OP_ADCI:
            begin
                sum = {1'b0, mem_byte} + {1'b0, acc}
                    + {8'h00, carry_in};
                result = sum[7:0];
                carry_out = sum[8];
                carry_we = 1'b1;
            end
            `BLAU_OP_RSUB, `BLAU_OP_RSUBI:
            begin
                sum = {1'b0, mem_byte} + {1'b0, ~acc}
                    + 9'h001;
                result = sum[7:0];
                carry_out = sum[8];
                carry_we = 1'b1;
            end
            `BLAU_OP_RSUBB:
            begin
                // Carry set means no borrow, so it is the carry-in as is
                sum = {1'b0, mem_byte} + {1'b0, ~acc}
                    + {8'h00, carry_in};
                result = sum[7:0];
                carry_out = sum[8];
                carry_we = 1'b1;
            end
            default:
                known = 1'b0;
        endcase
    end
endmodule // blau_alu
`default_nettype wire

// ### rtl/blau_unit.v
/*
 Fetch/execute sequencer around the ALU: fetches an opcode at the program
 counter, reads the operand via the operand pointer or program counter,
 then updates accumulator and carry flag.
 Assumes a synchronous memory answering mem_rd with mem_ack and data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blau_map.vh"
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - F1: accumulator OR pointed memory byte
// - F9: accumulator OR immediate byte
// - F3: accumulator XOR pointed memory byte
// - FB: accumulator XOR immediate byte
// - F2: accumulator AND pointed memory byte
// - FA: AND immediate, advance program counter
// - 76: rotate right through carry flag
// - FE: shift left, high bit to carry
// - 7E: rotate left through carry flag
// - F4: add memory byte, carry from carry-out
// - FC: add immediate byte like plain add
// - 74: add memory byte plus carry flag
// - 7C: add immediate byte plus carry flag
// - F5: memory minus accumulator via complement
// - Subtract carry flag: one means no borrow
// - FD: immediate byte minus accumulator
// - 75: memory minus accumulator minus not-carry
// - Memory operands read at operand pointer
// - Immediate operands at program counter, then increment
// - Fetch state, operand read state, then one execute state
module blau_unit (
    input wire ref_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [15:0] operand_ptr,
    input wire [7:0] mem_rdata,
    input wire mem_ack,
    output reg [15:0] mem_addr_r,
    output reg mem_rd_r,
    output reg [15:0] pc_r,
    output reg [7:0] acc_r,
    output reg carry_flag_r,
    output reg [2:0] state_r,
    output reg done_r,
    output reg bad_op_r
);
    //////////////////////////////////////////////////////////////////////////
    reg [7:0] opcode_r;
    reg [7:0] operand_r;
    wire [7:0] alu_result;
    wire alu_carry;
    wire alu_carry_we;
    wire alu_known;
    wire is_imm;
    wire is_mem;
    wire uses_operand;

    // Immediate forms have low nibble 9..D with upper nibble F or 7
    assign is_imm = (opcode_r == `BLAU_OP_ORI) | (opcode_r == `BLAU_OP_XRI)
        | (opcode_r == `BLAU_OP_ANDI) | (opcode_r == `BLAU_OP_ADDI)
        | (opcode_r == `BLAU_OP_ADCI) | (opcode_r == `BLAU_OP_RSUBI);
    assign is_mem = (opcode_r == `BLAU_OP_OR) | (opcode_r == `BLAU_OP_XOR)
        | (opcode_r == `BLAU_OP_AND) | (opcode_r == `BLAU_OP_ADD)
        | (opcode_r == `BLAU_OP_ADC) | (opcode_r == `BLAU_OP_RSUB)
        | (opcode_r == `BLAU_OP_RSUBB);
    assign uses_operand = is_imm | is_mem;

    blau_alu u_alu (
        .opcode(opcode_r),
        .acc(acc_r),
        .mem_byte(operand_r),
        .carry_in(carry_flag_r),
        .result(alu_result),
        .carry_out(alu_carry),
        .carry_we(alu_carry_we),
        .known(alu_known)
    );

    //////////////////////////////////////////////////////////////////////////
    // Sequencer; the operand read has its own read state before execute,
    // so the register update lands in the execute cycle that follows it
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= `BLAU_ST_FETCH;
            mem_addr_r <= `BLAU_ADDR_ZERO;
            mem_rd_r <= 1'b0;
            pc_r <= `BLAU_ADDR_ZERO;
            acc_r <= `BLAU_BYTE_ZERO;
            carry_flag_r <= 1'b0;
            opcode_r <= `BLAU_BYTE_ZERO;
            operand_r <= `BLAU_BYTE_ZERO;
            done_r <= 1'b0;
            bad_op_r <= 1'b0;
        end
        else if (clk_en)
        begin
            done_r <= 1'b0;
            bad_op_r <= 1'b0;
            case (state_r)
                `BLAU_ST_FETCH:
                begin
                    if (!mem_rd_r)
                    begin
                        mem_rd_r <= 1'b1;
                        mem_addr_r <= pc_r;
                    end
                    else if (mem_ack)
                    begin
                        mem_rd_r <= 1'b0;
                        opcode_r <= mem_rdata;
                        pc_r <= pc_r + `BLAU_PC_STEP;
                        state_r <= `BLAU_ST_READ;
                    end
                end
                `BLAU_ST_READ:
                begin
                    if (!uses_operand)
                        state_r <= `BLAU_ST_EXEC;
                    else if (!mem_rd_r)
                    begin
                        mem_rd_r <= 1'b1;
                        // Pointer choice by addressing form
                        mem_addr_r <= is_imm ? pc_r
                            : operand_ptr;
                    end
                    else if (mem_ack)
                    begin
                        mem_rd_r <= 1'b0;
                        operand_r <= mem_rdata;
                        if (is_imm)
                            pc_r <= pc_r + `BLAU_PC_STEP;
                        state_r <= `BLAU_ST_EXEC;
                    end
                end
                `BLAU_ST_EXEC:
                begin
                    // Unknown opcodes pass untouched and are flagged
                    if (alu_known)
                        acc_r <= alu_result;
                    if (alu_carry_we)
                        carry_flag_r <= alu_carry;
                    done_r <= alu_known;
                    bad_op_r <= ~alu_known;
                    state_r <= `BLAU_ST_FETCH;
                end
                default:
                    state_r <= `BLAU_ST_FETCH;
            endcase
        end
    end
endmodule // blau_unit
`default_nettype wire

// ### tb/blau_unit_assertions.sv
/* Port checker for blau_unit.
   Assumes one clock and an async active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module blau_unit_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic mem_ack,
    input wire logic [15:0] mem_addr_r,
    input wire logic mem_rd_r,
    input wire logic [15:0] pc_r,
    input wire logic [7:0] acc_r,
    input wire logic [2:0] state_r,
    input wire logic done_r,
    input wire logic bad_op_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic tk;
    assign tk = mem_ack && mem_rd_r && clk_en;
    sequence s_op_rd;
        tk && state_r == 3'b010;
    endsequence
    sequence s_exec_end;
        state_r == 3'b100 ##1 state_r == 3'b001;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    rd_hold_a: assert property (mem_rd_r && !mem_ack |=> mem_rd_r
        && $stable(mem_addr_r)) else $error("read dropped");
    ack_end_a: assert property (tk |=> !mem_rd_r)
        else $error("read kept");
    op_exec_a: assert property (s_op_rd |=> s_exec_end)
        else $error("no single exec");
    exec_done_a: assert property (state_r == 3'b100 && clk_en
        |=> done_r ^ bad_op_r) else $error("no done");
    acc_hold_a: assert property (state_r != 3'b100
        |=> $stable(acc_r)) else $error("acc moved");
    fetch_addr_a: assert property ($rose(mem_rd_r)
        && state_r == 3'b001 |-> mem_addr_r == pc_r) else $error("fetch");
    pc_step_a: assert property (tk && mem_addr_r == pc_r
        |=> pc_r == $past(pc_r) + 16'h0001) else $error("pc step");
    ptr_read_a: assert property (tk && mem_addr_r != pc_r
        |=> $stable(pc_r)) else $error("pc moved");
endmodule // blau_unit_chk
bind blau_unit blau_unit_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .mem_ack(mem_ack), .mem_addr_r(mem_addr_r),
    .mem_rd_r(mem_rd_r), .pc_r(pc_r), .acc_r(acc_r), .state_r(state_r),
    .done_r(done_r), .bad_op_r(bad_op_r));
`default_nettype wire

// ### tb/blau_mem_model.sv
/* Memory partner: answers reads, up to a granted count, promptly or slow.
   Assumes the bench fills mem directly before granting reads. */
`timescale 1ns/1ps
`default_nettype none
module blau_mem_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic mem_rd_r,
    input wire logic [15:0] mem_addr_r,
    input wire logic slow,
    input wire logic [15:0] grant,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [0:255];
    logic [15:0] acks_r;
    logic [1:0] wt_r;
    // Data toggles when not acked, so a stale byte is never mistaken
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_ack <= 1'b0;
            acks_r <= 16'h0000;
            wt_r <= 2'b00;
            mem_rdata <= 8'hA5;
        end
        else if (!mem_ack && mem_rd_r && acks_r != grant && wt_r >= {2{slow}})
        begin
            mem_ack <= 1'b1;
            acks_r <= acks_r + 16'h0001;
            mem_rdata <= mem[mem_addr_r[7:0]];
        end
        else
        begin
            mem_ack <= 1'b0;
            wt_r <= (mem_rd_r && !mem_ack) ? wt_r + 2'b01 : 2'b00;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // blau_mem_model
`default_nettype wire

// ### tb/test_byte_logic_arith_unit.sv
/* Self-checking bench for blau_unit with a memory partner.
   Assumes memory operands sit at address 0080 and programs start at 0000. */
`timescale 1ns/1ps
`default_nettype none
module test_byte_logic_arith_unit;
    logic ref_clk = 0, sys_rst = 1, slow = 0, cf = 0, cy, rd, ack, en = 1, bad;
    logic [2:0] st;
    logic [15:0] grant = 16'h0000, pc_x = 16'h0000, pc, ad;
    logic [7:0] acc, rdat;
    logic done;
    int error_cnt = 0, check_count = 0;
    always #2 ref_clk = ~ref_clk;
    blau_unit u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(en),
        .operand_ptr(16'h0080), .mem_rdata(rdat), .mem_ack(ack),
        .mem_addr_r(ad), .mem_rd_r(rd), .pc_r(pc), .acc_r(acc),
        .carry_flag_r(cy), .state_r(st), .done_r(done), .bad_op_r(bad));
    blau_mem_model u_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
        .mem_rd_r(rd), .mem_addr_r(ad), .grant(grant), .mem_rdata(rdat),
        .mem_ack(ack));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Runs one opcode; operand goes after it or to the pointer byte
    task op(input logic [7:0] c, input logic [7:0] v, input bit im,
        input bit sh, input logic [7:0] ea, input logic ec);
        int n;
        u_mem.mem[pc_x[7:0]] = c;
        if (!sh && im)
            u_mem.mem[pc_x[7:0] + 8'h01] = v;
        else if (!sh)
            u_mem.mem[8'h80] = v;
        grant = grant + (sh ? 16'h0001 : 16'h0002);
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (done !== 1'b1 && n < 60);
        if (done !== 1'b1)
        begin
            error_cnt++;
            print_verdict;
        end
        pc_x = pc_x + ((im && !sh) ? 16'h0002 : 16'h0001);
        chk({8'h00, acc}, {8'h00, ea});
        chk({15'h0000, cy}, {15'h0000, ec});
        chk(pc, pc_x);
        cf = ec;
    endtask
    task ld(input logic [7:0] v);
        op(8'hFA, 8'h00, 1, 0, 8'h00, cf);
        op(8'hF9, v, 1, 0, v, cf);
    endtask
    task t_logic;
        ld(8'h5A);
        op(8'hFC, 8'hF0, 1, 0, 8'h4A, 1);
        op(8'hF1, 8'h81, 0, 0, 8'hCB, 1);
        op(8'hF3, 8'hCB, 0, 0, 8'h00, 1);
        op(8'hFB, 8'hFF, 1, 0, 8'hFF, 1);
        op(8'hF2, 8'h0F, 0, 0, 8'h0F, 1);
        op(8'hFA, 8'h3C, 1, 0, 8'h0C, 1);
    endtask
    // Slow memory here: shifts must not depend on answer latency
    task t_shift;
        slow = 1;
        op(8'hF6, 8'h00, 0, 1, 8'h06, 0);
        op(8'hF9, 8'h81, 1, 0, 8'h87, 0);
        op(8'h7E, 8'h00, 0, 1, 8'h0E, 1);
        op(8'h76, 8'h00, 0, 1, 8'h87, 0);
        op(8'hFE, 8'h00, 0, 1, 8'h0E, 1);
        op(8'h7E, 8'h00, 0, 1, 8'h1D, 0);
        slow = 0;
    endtask
    task t_arith;
        ld(8'h3A);
        op(8'hF4, 8'hF0, 0, 0, 8'h2A, 1);
        ld(8'h3A);
        op(8'hF4, 8'h4B, 0, 0, 8'h85, 0);
        ld(8'h3D);
        op(8'h7C, 8'hC2, 1, 0, 8'hFF, 0);
        op(8'hFC, 8'h01, 1, 0, 8'h00, 1);
        ld(8'h2D);
        op(8'h74, 8'h3A, 0, 0, 8'h68, 0);
        ld(8'h0E);
        op(8'hF5, 8'h42, 0, 0, 8'h34, 1);
        ld(8'h77);
        op(8'hFD, 8'h42, 1, 0, 8'hCB, 0);
        ld(8'h20);
        op(8'h75, 8'h40, 0, 0, 8'h1F, 1);
        ld(8'hF2);
        op(8'h75, 8'h71, 0, 0, 8'h7F, 0);
    endtask
    // Stall, unknown opcode, then a reset in mid-run
    task t_misc;
        int n;
        u_mem.mem[pc_x[7:0]] = 8'h00;
        grant = grant + 16'h0001;
        en = 0;
        repeat (5) @(negedge ref_clk);
        chk({15'h0000, rd}, 16'h0000);
        chk(pc, pc_x);
        en = 1;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (bad !== 1'b1 && n < 60);
        chk({15'h0000, bad}, 16'h0001);
        chk({8'h00, acc}, 16'h007F);
        chk({15'h0000, cy}, {15'h0000, cf});
        chk(pc, pc_x + 16'h0001);
        sys_rst = 1;
        grant = 16'h0000;
        @(negedge ref_clk);
        chk({13'h0000, st}, 16'h0001);
        chk({8'h00, acc}, 16'h0000);
        sys_rst = 0;
        pc_x = 16'h0000;
        cf = 0;
        op(8'hF9, 8'h24, 1, 0, 8'h24, 0);
    endtask
    initial
    begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 0;
        t_logic;
        t_shift;
        t_arith;
        t_misc;
        print_verdict;
    end
endmodule // test_byte_logic_arith_unit
`default_nettype wire
